// *** design/mmf_regs.vh ***
/*
 Holds the selector codes and the fixed field values of the
 memory model feature identification registers.
 Assumes it is included once by bare name by each design file.
*/
`ifndef MMF_REGS_VH
`define MMF_REGS_VH

// ****************************************
// Coprocessor selector codes
// ****************************************
`define MMF_OPC1_ID        3'h0
`define MMF_CRN_ID         4'h0
`define MMF_CRM_FEAT       4'h1
`define MMF_OPC2_AUX       3'h3
`define MMF_OPC2_ZERO      3'h4
`define MMF_OPC2_ONE       3'h5
`define MMF_OPC2_TWO       3'h6

// ****************************************
// Word zero fields
// ****************************************
`define MMF0_RSVD_VAL      4'h0
`define MMF0_FCS_VAL       4'h0
`define MMF0_AUXCTL_VAL    4'h2
`define MMF0_TCM_VAL       4'h1
`define MMF0_OSH_VAL       4'h0
`define MMF0_COH_VAL       4'h0
`define MMF0_PPA_VAL       4'h3
`define MMF0_VMA_VAL       4'h0

// ****************************************
// Word one fields
// ****************************************
`define MMF1_BPRED_VAL     4'h0
`define MMF1_L1MAINT_VAL   28'h0000000

// ****************************************
// Word two fields
// ****************************************
`define MMF2_HAF_VAL       4'h0
`define MMF2_WFI_VAL       4'h1
`define MMF2_BAR_VAL       4'h2
`define MMF2_TLBPF_VAL     20'h00000

// ****************************************
// Auxiliary word and reset values
// ****************************************
`define MMF_AUX_VAL        32'h00000000
`define MMF_RDATA_RST      32'h00000000

`endif

// *** design/mmf_sel.v ***
/*
 Selector decode for the feature identification registers.
 Assumes selector fields are stable while the read strobe is high.
*/
`timescale 1ns/1ps
`include "mmf_regs.vh"

module mmf_sel (
    opc1,
    crn,
    crm,
    opc2,
    hit_aux,
    hit_zero,
    hit_one,
    hit_two
);
    input  wire [2:0] opc1;
    input  wire [3:0] crn;
    input  wire [3:0] crm;
    input  wire [2:0] opc2;
    output wire       hit_aux;
    output wire       hit_zero;
    output wire       hit_one;
    output wire       hit_two;

    wire base;

    assign base     = (opc1 == `MMF_OPC1_ID) && (crn == `MMF_CRN_ID) && (crm == `MMF_CRM_FEAT);
    assign hit_aux  = base && (opc2 == `MMF_OPC2_AUX);
    assign hit_zero = base && (opc2 == `MMF_OPC2_ZERO);
    assign hit_one  = base && (opc2 == `MMF_OPC2_ONE);
    assign hit_two  = base && (opc2 == `MMF_OPC2_TWO);
endmodule

// *** design/mmf_feature_id.v ***
/*
 Read-only auxiliary and memory model feature identification words,
 answered on the system control coprocessor read path.
 Assumes the core presents opcode and register selectors with a
 one-cycle read strobe and its current privilege level.
*/
`timescale 1ns/1ps
`include "mmf_regs.vh"

module mmf_feature_id (
    clk_sys,
    rst_b,
    cp_rd,
    cp_wr,
    cp_priv,
    cp_opc1,
    cp_crn,
    cp_crm,
    cp_opc2,
    cp_rdata,
    cp_rvalid,
    cp_hit,
    cp_fault
);
    input  wire        clk_sys;
    input  wire        rst_b;
    input  wire        cp_rd;
    input  wire        cp_wr;
    input  wire        cp_priv;
    input  wire [2:0]  cp_opc1;
    input  wire [3:0]  cp_crn;
    input  wire [3:0]  cp_crm;
    input  wire [2:0]  cp_opc2;
    output wire [31:0] cp_rdata;
    output wire        cp_rvalid;
    output wire        cp_hit;
    output wire        cp_fault;

    // ****************************************
    // Fixed words
    // ****************************************
    wire [31:0] word_aux;
    wire [31:0] word_zero;
    wire [31:0] word_one;
    wire [31:0] word_two;

    assign word_aux  = `MMF_AUX_VAL;
    assign word_zero = {`MMF0_RSVD_VAL, `MMF0_FCS_VAL,
                        `MMF0_AUXCTL_VAL,
                        `MMF0_TCM_VAL,
                        `MMF0_OSH_VAL,
                        `MMF0_COH_VAL,
                        `MMF0_PPA_VAL,
                        `MMF0_VMA_VAL};
    assign word_one  = {`MMF1_BPRED_VAL,
                        `MMF1_L1MAINT_VAL};
    assign word_two  = {`MMF2_HAF_VAL,
                        `MMF2_WFI_VAL,
                        `MMF2_BAR_VAL,
                        `MMF2_TLBPF_VAL};

    // ****************************************
    // Decode
    // ****************************************
    wire hit_aux;
    wire hit_zero;
    wire hit_one;
    wire hit_two;
    wire any_hit;

    mmf_sel u_sel (
        .opc1     (cp_opc1),
        .crn      (cp_crn),
        .crm      (cp_crm),
        .opc2     (cp_opc2),
        .hit_aux  (hit_aux),
        .hit_zero (hit_zero),
        .hit_one  (hit_one),
        .hit_two  (hit_two)
    );

    assign any_hit = hit_aux | hit_zero | hit_one | hit_two;

    // ****************************************
    // Read path
    // ****************************************
    reg  [31:0] rdata_q;
    reg  [31:0] rdata_d;
    reg         rvalid_q;
    reg         hit_q;
    reg         fault_q;
    wire        take_rd;
    wire        bad_acc;

    // Unprivileged access, or any write to a hit, is refused
    assign take_rd = cp_rd & cp_priv & any_hit & ~cp_wr;
    assign bad_acc = any_hit & ((cp_rd & ~cp_priv) | cp_wr);

    always @* begin
        rdata_d = `MMF_RDATA_RST;
        if (take_rd) begin
            if (hit_aux) begin
                rdata_d = word_aux;
            end else if (hit_zero) begin
                rdata_d = word_zero;
            end else if (hit_one) begin
                rdata_d = word_one;
            end else begin
                rdata_d = word_two;
            end
        end
    end

    // Words are constants: writes have no path into them
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            rdata_q  <= `MMF_RDATA_RST;
            rvalid_q <= 1'b0;
            hit_q    <= 1'b0;
            fault_q  <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= take_rd;
            hit_q    <= any_hit & (cp_rd | cp_wr);
            fault_q  <= bad_acc;
        end
    end

    assign cp_rdata  = rdata_q;
    assign cp_rvalid = rvalid_q;
    assign cp_hit    = hit_q;
    assign cp_fault  = fault_q;
endmodule

// *** bench/mmf_feature_id_properties.sv ***
/* Checker for the feature identification read path.
   Assumes it is bound to mmf_feature_id and sees only its ports. */
`timescale 1ns/1ps
module mmf_feature_id_chk (
    input wire        clk_sys,
    input wire        rst_b,
    input wire        cp_rd,
    input wire        cp_wr,
    input wire        cp_priv,
    input wire [2:0]  cp_opc1,
    input wire [3:0]  cp_crn,
    input wire [3:0]  cp_crm,
    input wire [2:0]  cp_opc2,
    input wire [31:0] cp_rdata,
    input wire        cp_rvalid,
    input wire        cp_hit,
    input wire        cp_fault
);
    // ****************************************
    // Read path checks
    // ****************************************
    wire sel = cp_opc1 == 3'h0 && cp_crn == 4'h0 && cp_crm == 4'h1 && cp_opc2 >= 3'h3
        && cp_opc2 <= 3'h6;
    wire rd_ok = cp_rd && !cp_wr && cp_priv && sel;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    word_zero_a: assert property (rd_ok && cp_opc2 == 3'h4 |=>
        cp_rvalid && cp_hit && cp_rdata == 32'h00210030) else $error("word zero bad");
    word_two_a: assert property (rd_ok && cp_opc2 == 3'h6 |=>
        cp_rvalid && cp_rdata == 32'h01200000) else $error("word two bad");
    zero_words_a: assert property (rd_ok && cp_opc2[0] |=>
        cp_rvalid && cp_rdata == 32'h00000000) else $error("zero word bad");
    unpriv_read_a: assert property (cp_rd && !cp_priv && sel |=>
        cp_fault && !cp_rvalid && cp_rdata == 32'h00000000) else $error("unpriv read");
    write_fault_a: assert property (cp_wr && sel |=>
        cp_fault && cp_hit && !cp_rvalid) else $error("write not refused");
    sel_miss_a: assert property ((cp_rd || cp_wr) && !sel |=>
        !cp_hit && !cp_fault && !cp_rvalid) else $error("miss answered");
    idle_quiet_a: assert property (!cp_rd && !cp_wr |=>
        cp_rdata == 32'h00000000 && !cp_rvalid && !cp_hit) else $error("idle output");
    one_cycle_a: assert property ($rose(cp_rvalid) && !$past(cp_rd) |->
        1'b0) else $error("valid without read");
endmodule
bind mmf_feature_id mmf_feature_id_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
    .cp_rd(cp_rd), .cp_wr(cp_wr), .cp_priv(cp_priv), .cp_opc1(cp_opc1), .cp_crn(cp_crn),
    .cp_crm(cp_crm), .cp_opc2(cp_opc2), .cp_rdata(cp_rdata), .cp_rvalid(cp_rvalid),
    .cp_hit(cp_hit), .cp_fault(cp_fault));

// *** bench/mmf_feature_id_bench.sv ***
/* Bench for the feature identification registers.
   Assumes the design and its checker are compiled first. */
`timescale 1ns/1ps
module mmf_feature_id_bench;
    reg         clk_sys, rst_b, cp_rd, cp_wr, cp_priv;
    reg  [2:0]  cp_opc1, cp_opc2;
    reg  [3:0]  cp_crn, cp_crm;
    wire [31:0] cp_rdata;
    wire        cp_rvalid, cp_hit, cp_fault;
    integer     n_fail, checks, cyc, i;
    mmf_feature_id u_mmf_feature_id (.clk_sys(clk_sys), .rst_b(rst_b), .cp_rd(cp_rd),
        .cp_wr(cp_wr), .cp_priv(cp_priv), .cp_opc1(cp_opc1), .cp_crn(cp_crn),
        .cp_crm(cp_crm), .cp_opc2(cp_opc2), .cp_rdata(cp_rdata), .cp_rvalid(cp_rvalid),
        .cp_hit(cp_hit), .cp_fault(cp_fault));
    // ****************************************
    // Clock, tasks and expectations
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task results;
    begin
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    end
    endtask
    task cmp(input [34:0] got, input [34:0] exp);
    begin
        checks = checks + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // One access, then rdata, rvalid, hit and fault in the answer cycle
    task acc(input rd, input wr, input pv, input [3:0] crm, input [2:0] o2, input [34:0] exp);
    begin
        @(posedge clk_sys); #1;
        cp_rd = rd; cp_wr = wr; cp_priv = pv; cp_crm = crm; cp_opc2 = o2;
        @(posedge clk_sys); #1;
        cp_rd = 1'b0; cp_wr = 1'b0;
        cmp({cp_rdata, cp_rvalid, cp_hit, cp_fault}, exp);
    end
    endtask
    function [34:0] rx(input [2:0] o);
        case (o)
            3'h3, 3'h5: rx = {32'h00000000, 3'h6};
            3'h4:       rx = {32'h00210030, 3'h6};
            3'h6:       rx = {32'h01200000, 3'h6};
            default:    rx = 35'h0;
        endcase
    endfunction
    initial begin
        n_fail = 0; checks = 0; cyc = 0; rst_b = 1'b0; cp_rd = 1'b0; cp_wr = 1'b0;
        cp_priv = 1'b0; cp_opc1 = 3'h0; cp_crn = 4'h0; cp_crm = 4'h0; cp_opc2 = 3'h0;
        repeat (6) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        for (i = 0; i < 8; i = i + 1) acc(1'b1, 1'b0, 1'b1, 4'h1, i, rx(i));
        $display("privileged reads done");
        for (i = 3; i < 7; i = i + 1) acc(1'b1, 1'b0, 1'b0, 4'h1, i, 35'h3);
        for (i = 3; i < 7; i = i + 1) acc(1'b0, 1'b1, 1'b1, 4'h1, i, 35'h3);
        acc(1'b1, 1'b1, 1'b1, 4'h1, 3'h4, 35'h3);
        for (i = 3; i < 7; i = i + 1) acc(1'b1, 1'b0, 1'b1, 4'h1, i, rx(i));
        $display("refused accesses done");
        acc(1'b1, 1'b0, 1'b1, 4'h2, 3'h4, 35'h0);
        cp_crn = 4'h1;
        acc(1'b1, 1'b0, 1'b1, 4'h1, 3'h4, 35'h0);
        cp_crn = 4'h0; cp_opc1 = 3'h1;
        acc(1'b1, 1'b0, 1'b1, 4'h1, 3'h6, 35'h0);
        $display("selector misses done");
        results;
    end
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 300) begin
            n_fail = n_fail + 1;
            results;
        end
    end
endmodule
